/* include/hulp_cfg.svh */
// Constants for the upstream link power manager: offsets, fields, timing.
`ifndef HULP_CFG_SVH
`define HULP_CFG_SVH

// ----------------------------------------------------------------------
// Structure
// ----------------------------------------------------------------------
`define HULP_NPORT 4
`define HULP_ADDR_W 4
`define HULP_DATA_W 32

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define HULP_OFS_CTRL 4'h0
`define HULP_OFS_TIMEOUT 4'h4
`define HULP_OFS_STATUS 4'h8

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HULP_CTRL_U1_EN 0
`define HULP_CTRL_U2_EN 1
`define HULP_CTRL_FORCE 2
`define HULP_CTRL_RW_CONN 3
`define HULP_CTRL_RW_PWR 4
`define HULP_CTRL_W 5
`define HULP_STAT_STATE_LSB 0
`define HULP_STAT_TMR_RUN 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define HULP_CTRL_RST 5'h00
`define HULP_TIMEOUT_RST 8'h00
`define HULP_RDATA_RST 32'h0000_0000

// ----------------------------------------------------------------------
// Reserved timeout codes that disable the U1 to U2 timeout
// ----------------------------------------------------------------------
`define HULP_TO_OFF_LO 8'h00
`define HULP_TO_OFF_HI 8'hFF

// ----------------------------------------------------------------------
// Timing: one timeout unit in ns, clock period in ns, cycles per unit
// ----------------------------------------------------------------------
`define HULP_PM_UNIT_NS 256000
`define HULP_CLK_NS 50
`define HULP_TICK_CYC \
  ((`HULP_PM_UNIT_NS + `HULP_CLK_NS - 1) / `HULP_CLK_NS)
`define HULP_TICK_W 16

`endif

/* include/hulp_pkg.sv */
// Types shared by the upstream link power manager modules.
package hulp_pkg;

  // ----------------------------------------------------------------------
  // Link states reported by each downstream port.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HULP_DS_U0,
    HULP_DS_U1,
    HULP_DS_U2,
    HULP_DS_U3,
    HULP_DS_REC,
    HULP_DS_OFF
  } hulp_ds_lnk_t;

  // ----------------------------------------------------------------------
  // Upstream port power management states.
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    HULP_ST_U0,
    HULP_ST_ATT_U1,
    HULP_ST_ATT_U2,
    HULP_ST_U1,
    HULP_ST_ATT_U12,
    HULP_ST_U2,
    HULP_ST_U3,
    HULP_ST_EXIT
  } hulp_st_t;

  // ----------------------------------------------------------------------
  // Link commands and events from the upstream link layer.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic go_u1;
    logic go_u2;
    logic go_u3;
    logic accept;
    logic reject;
    logic u0_done;
    logic wake;
    logic recovery;
  } hulp_lnk_rx_t;

  // ----------------------------------------------------------------------
  // Link commands asked of the upstream link layer.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic go_u1;
    logic go_u2;
    logic accept;
    logic reject;
    logic exit_u0;
  } hulp_lnk_tx_t;

  // ----------------------------------------------------------------------
  // Hub events that affect the upstream link.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic status_chg;
    logic ds_exit;
    logic pwr_chg;
  } hulp_hub_evt_t;

endpackage : hulp_pkg

/* verilog/hulp_ds_sum.sv */
// Summary of downstream port link states for entry decisions.
`timescale 1ns/100ps
`include "hulp_cfg.svh"
module hulp_ds_sum
  import hulp_pkg::*;
(
  input wire hulp_ds_lnk_t [`HULP_NPORT-1:0] ds_state,
  output logic all_ge_u1,
  output logic all_ge_u2
);

  // A port in U0 or recovery is active and qualifies for neither U1 nor U2.
  function automatic logic is_active(input hulp_ds_lnk_t s);
    is_active = (s == HULP_DS_U0) || (s == HULP_DS_REC);
  endfunction : is_active

  logic [`HULP_NPORT-1:0] ok_u1;
  logic [`HULP_NPORT-1:0] ok_u2;

  // Per port qualification for U1 depth and U2 depth.
  genvar i;
  generate
    for (i = 0; i < `HULP_NPORT; i++) begin : g_port
      assign ok_u1[i] = !is_active(ds_state[i]);
      assign ok_u2[i] = !is_active(ds_state[i]) &&
                        (ds_state[i] != HULP_DS_U1);
    end
  endgenerate

  // All ports must qualify.
  assign all_ge_u1 = &ok_u1;
  assign all_ge_u2 = &ok_u2;

endmodule : hulp_ds_sum

/* verilog/hulp_pm_timer.sv */
// PM timer for the U1 to U2 inactivity timeout.
`timescale 1ns/100ps
`include "hulp_cfg.svh"
module hulp_pm_timer
  import hulp_pkg::*;
#(
  parameter logic [`HULP_TICK_W-1:0] TICK_CYC = `HULP_TICK_W'(`HULP_TICK_CYC)
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic run,
  input wire logic [7:0] timeout,
  output logic hit
);

  logic [`HULP_TICK_W-1:0] tick_q;
  logic [7:0] units_q;
  logic armed;

  // The timer only fires for a timeout outside the two reserved codes.
  assign armed = (timeout != `HULP_TO_OFF_LO) &&
                 (timeout != `HULP_TO_OFF_HI);

  // Sub-unit cycle counter; it rounds up so the timer never runs early.
  always_ff @(posedge core_clk) begin
    if (srst || start || !run) begin
      tick_q <= '0;
    end else if (tick_q == TICK_CYC - 1'b1) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  // Whole unit counter, held once the timeout is reached.
  always_ff @(posedge core_clk) begin
    if (srst || start || !run) begin
      units_q <= 8'h00;
    end else if (tick_q == TICK_CYC - 1'b1 && units_q != timeout) begin
      units_q <= units_q + 8'h01;
    end
  end

  // Expiry flag, only meaningful while running.
  assign hit = run && !start && armed && (units_q == timeout);

endmodule : hulp_pm_timer

/* verilog/hulp_up_lpm.sv */
// Upstream port link power management controller with register port.
`timescale 1ns/100ps
`include "hulp_cfg.svh"
module hulp_up_lpm
  import hulp_pkg::*;
#(
  parameter logic [`HULP_TICK_W-1:0] TICK_CYC = `HULP_TICK_W'(`HULP_TICK_CYC)
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [`HULP_ADDR_W-1:0] reg_addr,
  input wire logic [`HULP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`HULP_DATA_W-1:0] reg_rdata,
  input wire hulp_lnk_rx_t lnk_rx,
  input wire logic lmp_to_vld,
  input wire logic [7:0] lmp_to_val,
  input wire logic tx_pending,
  input wire hulp_ds_lnk_t [`HULP_NPORT-1:0] ds_state,
  input wire hulp_hub_evt_t hub_evt,
  output hulp_lnk_tx_t lnk_tx,
  output hulp_st_t up_state
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [`HULP_CTRL_W-1:0] ctrl_q;
  logic [7:0] timeout_q;
  logic [`HULP_DATA_W-1:0] rdata_q;
  hulp_st_t state_q;
  hulp_st_t state_d;
  hulp_lnk_tx_t tx_q;
  hulp_lnk_tx_t tx_d;
  logic all_ge_u1;
  logic all_ge_u2;
  logic tmr_start;
  logic tmr_run;
  logic tmr_hit;
  logic u1_en;
  logic u2_en;
  logic force_acc;
  logic rw_conn;
  logic rw_pwr;
  logic can_u1;
  logic can_u2;
  logic wake_evt;
  logic exit_evt;

  // ----------------------------------------------------------------------
  // Control field views
  // ----------------------------------------------------------------------
  assign u1_en = ctrl_q[`HULP_CTRL_U1_EN];
  assign u2_en = ctrl_q[`HULP_CTRL_U2_EN];
  assign force_acc = ctrl_q[`HULP_CTRL_FORCE];
  assign rw_conn = ctrl_q[`HULP_CTRL_RW_CONN];
  assign rw_pwr = ctrl_q[`HULP_CTRL_RW_PWR];

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------

  // Control register: enables, force accept and remote wakeup mask.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_q <= `HULP_CTRL_RST;
    end else if (reg_wr && reg_addr == `HULP_OFS_CTRL) begin
      ctrl_q <= reg_wdata[`HULP_CTRL_W-1:0];
    end
  end

  // Timeout value, written only by a received timeout message.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timeout_q <= `HULP_TIMEOUT_RST;
    end else if (lmp_to_vld) begin
      timeout_q <= lmp_to_val;
    end
  end

  // Read data stands one cycle after the strobe and is zero otherwise.
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      rdata_q <= `HULP_RDATA_RST;
    end else begin
      unique case (reg_addr)
        `HULP_OFS_CTRL: rdata_q <= {27'h000_0000, ctrl_q};
        `HULP_OFS_TIMEOUT: rdata_q <= {24'h00_0000, timeout_q};
        `HULP_OFS_STATUS: rdata_q <= {23'h00_0000, tmr_run,
                                      5'h00, state_q};
        default: rdata_q <= `HULP_RDATA_RST;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  hulp_ds_sum u_ds_sum (
    .ds_state(ds_state),
    .all_ge_u1(all_ge_u1),
    .all_ge_u2(all_ge_u2)
  );

  // The timer runs only in U1 and restarts on every entry into U1.
  assign tmr_run = (state_q == HULP_ST_U1);
  assign tmr_start = (state_d == HULP_ST_U1) &&
                     (state_q != HULP_ST_U1);

  hulp_pm_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_pm_timer (
    .core_clk(core_clk),
    .srst(srst),
    .start(tmr_start),
    .run(tmr_run),
    .timeout(timeout_q),
    .hit(tmr_hit)
  );

  // Partner entry acceptance, overridden by force accept.
  assign can_u1 = force_acc || (!tx_pending && all_ge_u1);
  assign can_u2 = force_acc || (!tx_pending && all_ge_u2);

  // Events that pull U1 or U2 back to U0.
  assign exit_evt = hub_evt.status_chg || hub_evt.ds_exit;

  // Events that wake the link from U3, gated by the wakeup mask.
  assign wake_evt = (hub_evt.status_chg && rw_conn) ||
                    (hub_evt.pwr_chg && rw_pwr);

  // ----------------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------------

  // Next state and one-cycle link command requests.
  always_comb begin
    state_d = state_q;
    tx_d = '0;
    unique case (state_q)
      HULP_ST_U0: begin
        if (lnk_rx.go_u3) begin
          tx_d.accept = 1'b1;
          state_d = HULP_ST_U3;
        end else if (lnk_rx.go_u2) begin
          if (can_u2) begin
            tx_d.accept = 1'b1;
            state_d = HULP_ST_U2;
          end else begin
            tx_d.reject = 1'b1;
          end
        end else if (lnk_rx.go_u1) begin
          if (can_u1) begin
            tx_d.accept = 1'b1;
            state_d = HULP_ST_U1;
          end else begin
            tx_d.reject = 1'b1;
          end
        end else if (!tx_pending && !lnk_rx.recovery) begin
          if (u2_en && all_ge_u2) begin
            tx_d.go_u2 = 1'b1;
            state_d = HULP_ST_ATT_U2;
          end else if (u1_en && all_ge_u1) begin
            tx_d.go_u1 = 1'b1;
            state_d = HULP_ST_ATT_U1;
          end
        end
      end
      HULP_ST_ATT_U1: begin
        if (lnk_rx.accept) begin
          state_d = HULP_ST_U1;
        end else if (lnk_rx.reject || lnk_rx.recovery) begin
          state_d = HULP_ST_U0;
        end
      end
      HULP_ST_ATT_U2: begin
        if (lnk_rx.accept) begin
          state_d = HULP_ST_U2;
        end else if (lnk_rx.reject || lnk_rx.recovery) begin
          state_d = HULP_ST_U0;
        end
      end
      HULP_ST_U1: begin
        if (lnk_rx.u0_done) begin
          state_d = HULP_ST_U0;
        end else if (exit_evt) begin
          tx_d.exit_u0 = 1'b1;
          state_d = HULP_ST_EXIT;
        end else if (u2_en && all_ge_u2 && !tx_pending) begin
          tx_d.exit_u0 = 1'b1;
          state_d = HULP_ST_EXIT;
        end else if (tmr_hit) begin
          tx_d.go_u2 = 1'b1;
          state_d = HULP_ST_ATT_U12;
        end
      end
      HULP_ST_ATT_U12: begin
        if (lnk_rx.accept) begin
          state_d = HULP_ST_U2;
        end else if (lnk_rx.recovery) begin
          state_d = HULP_ST_U0;
        end else if (lnk_rx.reject) begin
          state_d = HULP_ST_U1;
        end
      end
      HULP_ST_U2: begin
        if (lnk_rx.u0_done) begin
          state_d = HULP_ST_U0;
        end else if (exit_evt) begin
          tx_d.exit_u0 = 1'b1;
          state_d = HULP_ST_EXIT;
        end
      end
      HULP_ST_U3: begin
        if (lnk_rx.wake || lnk_rx.u0_done) begin
          state_d = HULP_ST_U0;
        end else if (wake_evt) begin
          tx_d.exit_u0 = 1'b1;
          state_d = HULP_ST_EXIT;
        end
      end
      HULP_ST_EXIT: begin
        if (lnk_rx.u0_done) begin
          state_d = HULP_ST_U0;
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= HULP_ST_U0;
    end else begin
      state_q <= state_d;
    end
  end

  // Registered link command pulses.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  assign lnk_tx = tx_q;
  assign up_state = state_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  // All checks share the core clock and pause while reset is high.
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_exit_on_status: assert property (
    (state_q inside {HULP_ST_U1, HULP_ST_U2}) && hub_evt.status_chg &&
    !lnk_rx.u0_done |=> lnk_tx.exit_u0 && state_q == HULP_ST_EXIT)
    else $error("status change in U1 or U2 did not start exit");

  a_timeout_load: assert property (
    lmp_to_vld |=> timeout_q == $past(lmp_to_val))
    else $error("timeout value not loaded");

  a_timer_restart: assert property (
    tmr_start |=> !tmr_hit)
    else $error("timer fired right after U1 entry");

  a_no_init_pend: assert property (
    state_q == HULP_ST_U0 && tx_pending |=> !lnk_tx.go_u1 &&
    !lnk_tx.go_u2)
    else $error("entry started with traffic pending");

  a_force_accept: assert property (
    state_q == HULP_ST_U0 && force_acc && !lnk_rx.go_u3 &&
    (lnk_rx.go_u1 || lnk_rx.go_u2) |=> lnk_tx.accept)
    else $error("forced request not accepted");

  a_no_init_off: assert property (
    !u1_en && !u2_en && state_q == HULP_ST_U0 |=> !lnk_tx.go_u1 &&
    !lnk_tx.go_u2)
    else $error("entry started with both enables clear");

  a_u1_refuse: assert property (
    state_q == HULP_ST_U0 && lnk_rx.go_u1 && !lnk_rx.go_u2 &&
    !lnk_rx.go_u3 && !force_acc && (tx_pending || !all_ge_u1)
    |=> lnk_tx.reject && state_q == HULP_ST_U0)
    else $error("U1 request not refused");

  a_u2_refuse: assert property (
    state_q == HULP_ST_U0 && lnk_rx.go_u2 && !lnk_rx.go_u3 &&
    !force_acc && (tx_pending || !all_ge_u2)
    |=> lnk_tx.reject && state_q == HULP_ST_U0)
    else $error("U2 request not refused");

  a_u2_preferred: assert property (
    lnk_tx.go_u1 |-> !$past(u2_en) || !$past(all_ge_u2))
    else $error("U1 started although U2 was possible");

  a_u1_exit_first: assert property (
    state_q == HULP_ST_U1 && !lnk_rx.u0_done && !exit_evt && u2_en &&
    all_ge_u2 && !tx_pending |=> lnk_tx.exit_u0 &&
    state_q == HULP_ST_EXIT)
    else $error("U2 condition in U1 did not return to U0 first");

  a_attempt_fail: assert property (
    (state_q inside {HULP_ST_ATT_U1, HULP_ST_ATT_U2}) && !lnk_rx.accept &&
    (lnk_rx.reject || lnk_rx.recovery) |=> state_q == HULP_ST_U0)
    else $error("failed attempt did not return to U0");

  a_timer_u2: assert property (
    state_q == HULP_ST_U1 && tmr_hit && !lnk_rx.u0_done && !exit_evt &&
    !(u2_en && all_ge_u2 && !tx_pending)
    |=> lnk_tx.go_u2 && state_q == HULP_ST_ATT_U12)
    else $error("timeout did not start U1 to U2");

  a_u3_masked: assert property (
    state_q == HULP_ST_U3 && hub_evt.status_chg && !rw_conn &&
    !hub_evt.pwr_chg && !lnk_rx.wake && !lnk_rx.u0_done
    |=> state_q == HULP_ST_U3 && !lnk_tx.exit_u0)
    else $error("masked status change woke the link");

endmodule : hulp_up_lpm

/* testbench/hulp_lnk_partner.sv */
// Link partner model that answers the upstream port's link commands.
`timescale 1ns/100ps
module hulp_lnk_partner
  import hulp_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire hulp_lnk_tx_t lnk_tx,
  input wire hulp_lnk_rx_t req,
  input wire logic [1:0] mode,
  input wire logic [3:0] dly,
  output hulp_lnk_rx_t lnk_rx
);
  logic [4:0] ent_q;
  logic [4:0] ext_q;
  logic [1:0] rec_q;
  logic acc_q;
  logic rej_q;
  logic done_q;

  // Answers an entry attempt dly+2 cycles after the command pulse: accept, reject or recovery.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ent_q <= 5'h00;
      rec_q <= 2'h0;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      acc_q <= (ent_q == 5'h01) && (mode == 2'h0);
      rej_q <= (ent_q == 5'h01) && (mode == 2'h1);
      if (ent_q == 5'h01 && mode == 2'h2) begin
        rec_q <= 2'h3;
      end else if (rec_q != 2'h0) begin
        rec_q <= rec_q - 2'h1;
      end
      if (lnk_tx.go_u1 || lnk_tx.go_u2) begin
        ent_q <= {1'b0, dly} + 5'h01;
      end else if (ent_q != 5'h00) begin
        ent_q <= ent_q - 5'h01;
      end
    end
  end

  // Completes an exit to U0 some cycles after the port asks for it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ext_q <= 5'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= (ext_q == 5'h01);
      if (lnk_tx.exit_u0) begin
        ext_q <= {1'b0, dly} + 5'h01;
      end else if (ext_q != 5'h00) begin
        ext_q <= ext_q - 5'h01;
      end
    end
  end

  // Merges the bench's own requests with the model's answers.
  always_comb begin
    lnk_rx = req;
    lnk_rx.accept = req.accept | acc_q;
    lnk_rx.reject = req.reject | rej_q;
    lnk_rx.u0_done = req.u0_done | done_q;
    lnk_rx.recovery = req.recovery | (rec_q != 2'h0);
  end
endmodule : hulp_lnk_partner

/* testbench/tb.sv */
// Self-checking bench for the upstream link power manager.
`timescale 1ns/100ps
`include "hulp_cfg.svh"
module tb
  import hulp_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [`HULP_ADDR_W-1:0] reg_addr = 4'h0;
  logic [`HULP_DATA_W-1:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`HULP_DATA_W-1:0] reg_rdata;
  hulp_lnk_rx_t lnk_rx;
  hulp_lnk_rx_t req = '0;
  logic lmp_to_vld = 1'b0;
  logic [7:0] lmp_to_val = 8'h00;
  logic tx_pending = 1'b0;
  hulp_ds_lnk_t [`HULP_NPORT-1:0] ds_state = {`HULP_NPORT{HULP_DS_U0}};
  hulp_hub_evt_t hub_evt = '0;
  hulp_lnk_tx_t lnk_tx;
  hulp_st_t up_state;
  logic [1:0] mode = 2'h0;
  logic [3:0] dly = 4'h2;
  int failures = 0;
  int cmp_count = 0;
  int n_go1 = 0;
  int n_go2 = 0;
  int n_rej = 0;
  int n_acc = 0;
  int n;

  // ----------------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------------
  always #25 core_clk = ~core_clk;

  hulp_up_lpm #(.TICK_CYC(16'h0004)) dut (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lnk_rx(lnk_rx),
    .lmp_to_vld(lmp_to_vld), .lmp_to_val(lmp_to_val),
    .tx_pending(tx_pending), .ds_state(ds_state), .hub_evt(hub_evt),
    .lnk_tx(lnk_tx), .up_state(up_state));

  hulp_lnk_partner partner (.core_clk(core_clk), .srst(srst),
    .lnk_tx(lnk_tx), .req(req), .mode(mode), .dly(dly), .lnk_rx(lnk_rx));

  // Counts the one-cycle entry, accept and reject command pulses that the port sends.
  always @(posedge core_clk) begin
    if (!srst) begin
      n_go1 += int'(lnk_tx.go_u1);
      n_go2 += int'(lnk_tx.go_u2);
      n_rej += int'(lnk_tx.reject);
      n_acc += int'(lnk_tx.accept);
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask : rd

  // Pulses partner requests and hub events for one cycle.
  task automatic pulse(input hulp_lnk_rx_t rx, input hulp_hub_evt_t ev);
    @(posedge core_clk);
    req <= rx;
    hub_evt <= ev;
    @(posedge core_clk);
    req <= '0;
    hub_evt <= '0;
  endtask : pulse

  task automatic lmp(input logic [7:0] v);
    @(posedge core_clk);
    lmp_to_vld <= 1'b1;
    lmp_to_val <= v;
    @(posedge core_clk);
    lmp_to_vld <= 1'b0;
  endtask : lmp

  task automatic ds(input hulp_ds_lnk_t v);
    @(posedge core_clk);
    ds_state <= {`HULP_NPORT{v}};
  endtask : ds

  // Waits a bounded time for a port state, then compares it.
  task automatic wait_st(input hulp_st_t s);
    int i;
    for (i = 0; i < 60; i++) begin
      #1;
      if (up_state === s) break;
      @(posedge core_clk);
    end
    if (i == 60) begin
      failures++;
      report_and_stop();
    end
    check("up_state", 32'(up_state), 32'(s));
  endtask : wait_st

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h0000_0000);
    rd(4'h8, 32'h0000_0000);
    rd(4'hC, 32'h0000_0000);
    wr(4'h0, 32'hFFFF_FFFF);
    rd(4'h0, 32'h0000_001F);
    wr(4'h0, 32'h0000_0000);
    // Both enables clear: no entry of its own, partner U1 accepted.
    ds(HULP_DS_U2);
    repeat (20) @(posedge core_clk);
    check("go count", 32'(n_go1 + n_go2), 32'h0000_0000);
    pulse(8'h80, 3'h0);
    wait_st(HULP_ST_U1);
    pulse(8'h00, 3'h4);
    wait_st(HULP_ST_EXIT);
    wait_st(HULP_ST_U0);
    // Partner requests refused, a U1 request with a port in U1 accepted, then forced.
    dly <= 4'h0;
    @(posedge core_clk);
    ds_state[0] <= HULP_DS_U1;
    pulse(8'h40, 3'h0);
    repeat (3) @(posedge core_clk);
    check("reject count", 32'(n_rej), 32'h0000_0001);
    pulse(8'h80, 3'h0);
    wait_st(HULP_ST_U1);
    pulse(8'h00, 3'h2);
    wait_st(HULP_ST_EXIT);
    wait_st(HULP_ST_U0);
    @(posedge core_clk);
    ds_state[0] <= HULP_DS_U0;
    pulse(8'h80, 3'h0);
    ds(HULP_DS_U2);
    tx_pending <= 1'b1;
    pulse(8'h40, 3'h0);
    repeat (3) @(posedge core_clk);
    check("reject count", 32'(n_rej), 32'h0000_0003);
    wr(4'h0, 32'h0000_0004);
    pulse(8'h40, 3'h0);
    wait_st(HULP_ST_U2);
    pulse(8'h04, 3'h0);
    wait_st(HULP_ST_U0);
    check("accept count", 32'(n_acc), 32'h0000_0003);
    // U1 only: pending traffic blocks, then a rejected attempt.
    mode <= 2'h1;
    dly <= 4'h6;
    wr(4'h0, 32'h0000_0001);
    repeat (10) @(posedge core_clk);
    check("go_u1 count", 32'(n_go1), 32'h0000_0000);
    tx_pending <= 1'b0;
    wait_st(HULP_ST_ATT_U1);
    wait_st(HULP_ST_U0);
    check("go_u2 count", 32'(n_go2), 32'h0000_0000);
    ds(HULP_DS_U0);
    repeat (12) @(posedge core_clk);
    // U2 only: waits for all ports at U2, attempt lost to recovery.
    mode <= 2'h2;
    n = n_go1;
    wr(4'h0, 32'h0000_0002);
    ds(HULP_DS_U1);
    repeat (10) @(posedge core_clk);
    check("go count", 32'(n_go1 + n_go2 - n), 32'h0000_0000);
    ds(HULP_DS_U2);
    wait_st(HULP_ST_ATT_U2);
    wait_st(HULP_ST_U0);
    ds(HULP_DS_U0);
    repeat (12) @(posedge core_clk);
    // Both enabled: U1 first, then out to U0 before U2.
    mode <= 2'h0;
    wr(4'h0, 32'h0000_0003);
    ds(HULP_DS_U1);
    wait_st(HULP_ST_ATT_U1);
    wait_st(HULP_ST_U1);
    ds(HULP_DS_U2);
    wait_st(HULP_ST_EXIT);
    wait_st(HULP_ST_U0);
    wait_st(HULP_ST_ATT_U2);
    wait_st(HULP_ST_U2);
    ds(HULP_DS_U0);
    pulse(8'h00, 3'h4);
    wait_st(HULP_ST_EXIT);
    wait_st(HULP_ST_U0);
    // Inactivity timeout of two units from U1 entry.
    wr(4'h0, 32'h0000_0001);
    lmp(8'h02);
    rd(4'h4, 32'h0000_0002);
    ds(HULP_DS_U1);
    wait_st(HULP_ST_U1);
    n = 0;
    while (up_state !== HULP_ST_ATT_U12 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("timer window", 32'(n >= 8 && n <= 16), 32'h0000_0001);
    wait_st(HULP_ST_ATT_U12);
    wait_st(HULP_ST_U2);
    ds(HULP_DS_U0);
    pulse(8'h04, 3'h0);
    wait_st(HULP_ST_U0);
    lmp(8'hFF);
    ds(HULP_DS_U1);
    wait_st(HULP_ST_U1);
    repeat (30) @(posedge core_clk);
    check("up_state", 32'(up_state), 32'(HULP_ST_U1));
    rd(4'h8, 32'h0000_0103);
    ds(HULP_DS_U0);
    pulse(8'h04, 3'h0);
    wait_st(HULP_ST_U0);
    // Suspend: masked change ignored, wake and enabled events resume.
    wr(4'h0, 32'h0000_0000);
    pulse(8'h20, 3'h0);
    wait_st(HULP_ST_U3);
    pulse(8'h00, 3'h4);
    repeat (10) @(posedge core_clk);
    check("up_state", 32'(up_state), 32'(HULP_ST_U3));
    pulse(8'h02, 3'h0);
    wait_st(HULP_ST_U0);
    pulse(8'h20, 3'h0);
    wait_st(HULP_ST_U3);
    wr(4'h0, 32'h0000_0010);
    pulse(8'h00, 3'h1);
    wait_st(HULP_ST_U0);
    pulse(8'h20, 3'h0);
    wait_st(HULP_ST_U3);
    wr(4'h0, 32'h0000_0008);
    pulse(8'h00, 3'h4);
    wait_st(HULP_ST_U0);
    report_and_stop();
  end
endmodule : tb
